//--- hdl/dsplmd_decoder.sv
// Load / multiply opcode decoder of a 16-bit fixed-point DSP core.
// Assumes program memory presents one word per i_instr_valid pulse,
// on i_clk, the second word of a two-word form as the next valid word, after any idle cycles.
`timescale 1ns/1ns
module dsplmd_decoder (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  // Instruction words
  input  wire logic                   i_instr_valid,
  input  wire logic [15:0]            i_instr,
  // Decoded operation
  output logic                        o_op_valid,
  output dsplmd_pkg::dsplmd_op_t      o_op,
  output logic [1:0]                  o_words,
  output logic [1:0]                  o_cycles,
  output logic [2:0]                  o_aux_sel,
  output logic [15:0]                 o_imm,
  output logic [4:0]                  o_shift,
  output logic                        o_acc_clear,
  output logic                        o_unknown,
  output logic                        o_await_const,
  // Operand address field
  output logic                        o_mem_ref,
  output logic                        o_indirect,
  output logic [6:0]                  o_dir_offset,
  output logic [6:0]                  o_ind_mode
);

  ////////////////////////////////////////////////////////////////////////
  // Word fields
  dsplmd_pkg::dsplmd_state_t state_q;
  dsplmd_pkg::dsplmd_state_t state_d;
  wire [7:0] hb = i_instr[15:8];
  wire [7:0] lb = i_instr[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Pattern matches
  wire m_acc_short  = hb == dsplmd_pkg::HB_ACC_SHORT;
  wire m_acc_high   = hb == dsplmd_pkg::HB_ACC_HIGH;
  wire m_acc_low    = hb == dsplmd_pkg::HB_ACC_LOW;
  wire m_acc_tshift = hb == dsplmd_pkg::HB_ACC_TSHIFT;
  wire m_aux_mem    = i_instr[15:11] == dsplmd_pkg::TOP_AUX_MEM;
  wire m_aux_short  = i_instr[15:11] == dsplmd_pkg::TOP_AUX_SHORT;
  wire m_aux_long   = hb == dsplmd_pkg::HB_EXT_BF
                    && i_instr[7:3] == dsplmd_pkg::LO_AUX_LONG;
  wire m_page_mem   = hb == dsplmd_pkg::HB_PAGE_MEM;
  wire m_page_imm   = i_instr[15:9] == dsplmd_pkg::TOP_PAGE_IMM;
  wire m_status0    = hb == dsplmd_pkg::HB_STATUS0;
  wire m_status1    = hb == dsplmd_pkg::HB_STATUS1;
  wire m_temp       = hb == dsplmd_pkg::HB_TEMP;
  wire m_temp_acc   = hb == dsplmd_pkg::HB_TEMP_ACC;
  wire m_temp_pmove = hb == dsplmd_pkg::HB_TEMP_PMOVE;
  wire m_temp_sub   = hb == dsplmd_pkg::HB_TEMP_SUB;
  wire m_temp_accmv = hb == dsplmd_pkg::HB_TEMP_ACCMV;
  wire m_prod_high  = hb == dsplmd_pkg::HB_PROD_HIGH;
  wire m_mac        = hb == dsplmd_pkg::HB_MAC;
  wire m_multiply_accumulate_move_op       = hb == dsplmd_pkg::HB_MULTIPLY_ACCUMULATE_MOVE_OP;
  wire m_aux_mod    = hb == dsplmd_pkg::HB_AUX_MOD;
  wire m_aux_ptr    = m_aux_mod
                    && i_instr[7:3] == dsplmd_pkg::LO_AUX_PTR;
  wire m_mult       = hb == dsplmd_pkg::HB_MULT;
  wire m_mult_imm   = i_instr[15:13] == dsplmd_pkg::TOP_MULT_IMM;
  wire m_mult_add   = hb == dsplmd_pkg::HB_MULT_ADD;
  wire m_mult_sub   = hb == dsplmd_pkg::HB_MULT_SUB;
  wire m_mult_uns   = hb == dsplmd_pkg::HB_MULT_UNS;
  wire m_normalize_op       = hb == dsplmd_pkg::HB_NORMALIZE_OP;
  wire m_or_mem     = hb == dsplmd_pkg::HB_OR_MEM;
  wire m_or_shift   = hb == dsplmd_pkg::HB_EXT_BF
                    && i_instr[7:4] == dsplmd_pkg::NIB_OR_SHIFT;
  wire m_or16       = hb == dsplmd_pkg::HB_EXT_BE
                    && lb == dsplmd_pkg::LB_OR16;
  wire m_pac        = hb == dsplmd_pkg::HB_EXT_BE
                    && lb == dsplmd_pkg::LB_PAC;

  ////////////////////////////////////////////////////////////////////////
  // Operation select; pointer load outranks generic modify
  dsplmd_pkg::dsplmd_op_t op_dec;
  assign op_dec =
      m_acc_short  ? dsplmd_pkg::acc_short_load_op :
      m_acc_high   ? dsplmd_pkg::acc_high_load_op :
      m_acc_low    ? dsplmd_pkg::acc_low_load_op :
      m_acc_tshift ? dsplmd_pkg::acc_load_temp_multiplier_register_shift_op :
      m_aux_mem    ? dsplmd_pkg::aux_reg_load_op :
      m_aux_short  ? dsplmd_pkg::aux_short_load_op :
      m_aux_long   ? dsplmd_pkg::aux_long_load_op :
      m_page_mem   ? dsplmd_pkg::page_pointer_load_op :
      m_page_imm   ? dsplmd_pkg::page_imm_load_op :
      m_status0    ? dsplmd_pkg::status_load_op :
      m_status1    ? dsplmd_pkg::status_one_load_op :
      m_temp       ? dsplmd_pkg::temp_reg_load_op :
      m_temp_acc   ? dsplmd_pkg::temp_load_accumulate_op :
      m_temp_pmove ? dsplmd_pkg::temp_load_product_move_op :
      m_temp_sub   ? dsplmd_pkg::temp_load_subtract_op :
      m_temp_accmv ? dsplmd_pkg::temp_load_acc_move_op :
      m_prod_high  ? dsplmd_pkg::product_high_load_op :
      m_mac        ? dsplmd_pkg::multiply_accumulate_op :
      m_multiply_accumulate_move_op       ? dsplmd_pkg::multiply_accumulate_move_op :
      m_aux_ptr    ? dsplmd_pkg::aux_ptr_load_op :
      m_aux_mod    ? dsplmd_pkg::aux_reg_modify_op :
      m_mult       ? dsplmd_pkg::multiply_op :
      m_mult_imm   ? dsplmd_pkg::multiply_imm_op :
      m_mult_add   ? dsplmd_pkg::multiply_add_prev_op :
      m_mult_sub   ? dsplmd_pkg::multiply_sub_prev_op :
      m_mult_uns   ? dsplmd_pkg::multiply_unsigned_op :
      m_normalize_op       ? dsplmd_pkg::normalize_op :
      m_or_mem     ? dsplmd_pkg::or_mem_op :
      m_or_shift   ? dsplmd_pkg::or_imm_shift_op :
      m_or16       ? dsplmd_pkg::or_imm_high_op :
      m_pac        ? dsplmd_pkg::product_to_acc_op :
                     dsplmd_pkg::none_op;

  ////////////////////////////////////////////////////////////////////////
  // Length, timing and fields
  wire two_word  = m_aux_long | m_mac | m_multiply_accumulate_move_op | m_or_shift | m_or16;
  wire cyc_three = m_mac | m_multiply_accumulate_move_op;
  wire cyc_two   = m_aux_mem | m_aux_short | m_aux_long | m_page_mem
                 | m_page_imm | m_status0 | m_status1
                 | m_or_shift | m_or16;
  wire [1:0] words_dec  = two_word ? dsplmd_pkg::WORDS_TWO : dsplmd_pkg::WORDS_ONE;
  wire [1:0] cycles_dec = cyc_three ? dsplmd_pkg::CYC_THREE :
                          cyc_two   ? dsplmd_pkg::CYC_TWO : dsplmd_pkg::CYC_ONE;

  // Memory-operand forms carry an address field in the low byte
  wire mem_ref = m_acc_high | m_acc_low | m_acc_tshift | m_aux_mem
               | m_page_mem | m_status0 | m_status1 | m_temp | m_temp_acc
               | m_temp_pmove | m_temp_sub | m_temp_accmv | m_prod_high
               | m_mac | m_multiply_accumulate_move_op | (m_aux_mod & ~m_aux_ptr) | m_mult
               | m_mult_add | m_mult_sub | m_mult_uns | m_normalize_op | m_or_mem;

  wire [2:0] aux_dec = (m_aux_long | m_aux_ptr) ? i_instr[2:0]
                                                : i_instr[10:8];
  wire [15:0] imm_dec = m_mult_imm ? {3'h0, i_instr[12:0]} :
                        m_page_imm ? {7'h00, i_instr[8:0]} :
                                     {8'h00, lb};
  wire [4:0] shift_dec = m_or16     ? dsplmd_pkg::SHIFT_OR16 :
                         m_or_shift ? {1'b0, i_instr[3:0]} :
                                      5'h00;
  wire clear_dec = m_acc_short && lb == dsplmd_pkg::CONST_ZERO;

  ////////////////////////////////////////////////////////////////////////
  // Word sequencing
  wire take_op    = i_instr_valid && state_q == dsplmd_pkg::st_opcode;
  wire take_const = i_instr_valid && state_q == dsplmd_pkg::st_constant;
  wire emit       = (take_op && !two_word) || take_const;

  // Two-word forms hold the result back until the constant arrives
  assign state_d = (take_op && two_word) ? dsplmd_pkg::st_constant :
                   take_const            ? dsplmd_pkg::st_opcode  : state_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q    <= dsplmd_pkg::st_opcode;
      o_op_valid <= 1'b0;
    end else begin
      state_q    <= state_d;
      o_op_valid <= emit;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_op        <= dsplmd_pkg::none_op;
      o_words     <= dsplmd_pkg::WORDS_ONE;
      o_cycles    <= dsplmd_pkg::CYC_ONE;
      o_aux_sel   <= 3'h0;
      o_shift     <= 5'h00;
      o_acc_clear <= 1'b0;
      o_unknown   <= 1'b0;
    end else if (take_op) begin
      o_op        <= op_dec;
      o_words     <= words_dec;
      o_cycles    <= cycles_dec;
      o_aux_sel   <= aux_dec;
      o_shift     <= shift_dec;
      o_acc_clear <= clear_dec;
      o_unknown   <= op_dec == dsplmd_pkg::none_op;
    end
  end

  // Constant word replaces the short immediate for two-word forms
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_imm <= 16'h0000;
    end else if (take_op) begin
      o_imm <= imm_dec;
    end else if (take_const) begin
      o_imm <= i_instr;
    end
  end

  assign o_await_const = state_q;

  ////////////////////////////////////////////////////////////////////////
  // Address field
  dsplmd_addr_field u_addr (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_load       (take_op),
    .i_mem_ref    (mem_ref),
    .i_field      (lb),
    .o_mem_ref    (o_mem_ref),
    .o_indirect   (o_indirect),
    .o_dir_offset (o_dir_offset),
    .o_ind_mode   (o_ind_mode)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_take(logic [7:0] h);
    state_q == dsplmd_pkg::st_opcode && i_instr_valid && hb == h;
  endsequence

  sequence s_const_next;
    i_instr_valid;
  endsequence

  short_load_a: assert property (
    s_take(dsplmd_pkg::HB_ACC_SHORT) |=> o_op_valid
      && o_op == dsplmd_pkg::acc_short_load_op && o_imm == {8'h00, $past(lb)}
      && o_acc_clear == ($past(lb) == dsplmd_pkg::CONST_ZERO))
    else $error("short accumulator load misdecoded");

  high_load_a: assert property (
    s_take(dsplmd_pkg::HB_ACC_HIGH) |=> o_op_valid
      && o_op == dsplmd_pkg::acc_high_load_op && o_cycles == dsplmd_pkg::CYC_ONE)
    else $error("high accumulator load misdecoded");

  aux_short_a: assert property (
    (take_op && i_instr[15:11] == dsplmd_pkg::TOP_AUX_SHORT) |=> o_op_valid
      && o_cycles == dsplmd_pkg::CYC_TWO && o_aux_sel == $past(i_instr[10:8]))
    else $error("short aux load misdecoded");

  aux_long_a: assert property (
    (take_op && m_aux_long) ##1 s_const_next |=> o_op_valid
      && o_op == dsplmd_pkg::aux_long_load_op && o_imm == $past(i_instr)
      && o_words == dsplmd_pkg::WORDS_TWO && o_aux_sel == $past(i_instr[2:0], 2))
    else $error("long aux load misdecoded");

  page_imm_a: assert property (
    (take_op && m_page_imm) |=> o_op_valid
      && o_imm == {7'h00, $past(i_instr[8:0])} && o_cycles == dsplmd_pkg::CYC_TWO)
    else $error("page immediate misdecoded");

  status_one_a: assert property (
    s_take(dsplmd_pkg::HB_STATUS1) |=> o_op_valid
      && o_op == dsplmd_pkg::status_one_load_op && o_cycles == dsplmd_pkg::CYC_TWO)
    else $error("status load misdecoded");

  // Constant may lag the opcode by any number of idle cycles
  mac_hold_a: assert property (
    s_take(dsplmd_pkg::HB_MAC) |=> !o_op_valid && o_await_const
      && o_op == dsplmd_pkg::multiply_accumulate_op && o_cycles == dsplmd_pkg::CYC_THREE)
    else $error("multiply-accumulate sequence wrong");

  mac_done_a: assert property (
    s_take(dsplmd_pkg::HB_MAC) ##1 s_const_next |=> o_op_valid
      && o_imm == $past(i_instr) && o_words == dsplmd_pkg::WORDS_TWO)
    else $error("multiply-accumulate constant lost");

  const_wait_a: assert property (
    (o_await_const && !i_instr_valid) |=> o_await_const && !o_op_valid)
    else $error("constant wait not held");

  mult_imm_a: assert property (
    (take_op && m_mult_imm) |=> o_op_valid
      && o_op == dsplmd_pkg::multiply_imm_op && o_imm == {3'h0, $past(i_instr[12:0])})
    else $error("multiply immediate misdecoded");

  or_high_a: assert property (
    (take_op && m_or16) |=> o_shift == dsplmd_pkg::SHIFT_OR16 && !o_op_valid)
    else $error("shifted-16 OR misdecoded");

  pac_move_a: assert property (
    (take_op && m_pac) |=> o_op_valid && o_op == dsplmd_pkg::product_to_acc_op
      && o_words == dsplmd_pkg::WORDS_ONE && !o_mem_ref)
    else $error("product move misdecoded");

  addr_mode_a: assert property (
    (take_op && m_normalize_op) |=> o_mem_ref && o_indirect == $past(lb[7])
      && (o_indirect ? o_ind_mode : o_dir_offset) == $past(lb[6:0]))
    else $error("address field misdecoded");

  multiply_accumulate_move_op_hold_a: assert property (
    s_take(dsplmd_pkg::HB_MULTIPLY_ACCUMULATE_MOVE_OP) |=> !o_op_valid && o_words == dsplmd_pkg::WORDS_TWO
      && o_op == dsplmd_pkg::multiply_accumulate_move_op && o_cycles == dsplmd_pkg::CYC_THREE)
    else $error("data-move multiply misdecoded");

  low_load_a: assert property (
    s_take(dsplmd_pkg::HB_ACC_LOW) |=> o_op_valid
      && o_op == dsplmd_pkg::acc_low_load_op && o_mem_ref && o_cycles == dsplmd_pkg::CYC_ONE)
    else $error("low accumulator load misdecoded");

  temp_multiplier_register_shift_a: assert property (
    s_take(dsplmd_pkg::HB_ACC_TSHIFT) |=> o_op_valid
      && o_op == dsplmd_pkg::acc_load_temp_multiplier_register_shift_op && o_mem_ref)
    else $error("shifted accumulator load misdecoded");

  aux_mem_a: assert property (
    (take_op && m_aux_mem) |=> o_op == dsplmd_pkg::aux_reg_load_op
      && o_cycles == dsplmd_pkg::CYC_TWO && o_aux_sel == $past(i_instr[10:8]))
    else $error("aux memory load misdecoded");

  page_mem_a: assert property (
    s_take(dsplmd_pkg::HB_PAGE_MEM) |=> o_op == dsplmd_pkg::page_pointer_load_op
      && o_cycles == dsplmd_pkg::CYC_TWO && o_mem_ref)
    else $error("page memory load misdecoded");

  aux_ptr_a: assert property (
    (take_op && m_aux_ptr) |=> o_op == dsplmd_pkg::aux_ptr_load_op
      && o_aux_sel == $past(i_instr[2:0]) && !o_mem_ref)
    else $error("aux pointer load misdecoded");

  or_shift_a: assert property (
    (take_op && m_or_shift) |=> !o_op_valid && o_await_const
      && o_shift == {1'b0, $past(i_instr[3:0])})
    else $error("shifted OR misdecoded");

  unknown_a: assert property (
    (take_op && op_dec == dsplmd_pkg::none_op) |=> o_op_valid
      && o_unknown && o_words == dsplmd_pkg::WORDS_ONE)
    else $error("unknown opcode misdecoded");

endmodule : dsplmd_decoder

//--- hdl/dsplmd_pkg.sv
// Constants and types for the load/multiply opcode decoder.
// Assumes 16-bit instruction words on the decoder's own clock.
package dsplmd_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Opcode high bytes
  localparam logic [7:0] HB_ACC_SHORT  = 8'hB9;
  localparam logic [7:0] HB_ACC_HIGH   = 8'h6A;
  localparam logic [7:0] HB_ACC_LOW    = 8'h69;
  localparam logic [7:0] HB_ACC_TSHIFT = 8'h6B;
  localparam logic [7:0] HB_PAGE_MEM   = 8'h0D;
  localparam logic [7:0] HB_STATUS0    = 8'h0E;
  localparam logic [7:0] HB_STATUS1    = 8'h0F;
  localparam logic [7:0] HB_TEMP       = 8'h73;
  localparam logic [7:0] HB_TEMP_ACC   = 8'h70;
  localparam logic [7:0] HB_TEMP_PMOVE = 8'h71;
  localparam logic [7:0] HB_TEMP_ACCMV = 8'h72;
  localparam logic [7:0] HB_TEMP_SUB   = 8'h74;
  localparam logic [7:0] HB_PROD_HIGH  = 8'h75;
  localparam logic [7:0] HB_MAC        = 8'hA2;
  localparam logic [7:0] HB_MULTIPLY_ACCUMULATE_MOVE_OP       = 8'hA3;
  localparam logic [7:0] HB_AUX_MOD    = 8'h8B;
  localparam logic [7:0] HB_MULT       = 8'h54;
  localparam logic [7:0] HB_MULT_ADD   = 8'h50;
  localparam logic [7:0] HB_MULT_SUB   = 8'h51;
  localparam logic [7:0] HB_MULT_UNS   = 8'h55;
  localparam logic [7:0] HB_NORMALIZE_OP       = 8'hA0;
  localparam logic [7:0] HB_OR_MEM     = 8'h6D;
  localparam logic [7:0] HB_EXT_BF     = 8'hBF;
  localparam logic [7:0] HB_EXT_BE     = 8'hBE;

  ////////////////////////////////////////////////////////////////////////
  // Partial patterns
  localparam logic [4:0] TOP_AUX_MEM   = 5'h00;
  localparam logic [4:0] TOP_AUX_SHORT = 5'h16;
  localparam logic [6:0] TOP_PAGE_IMM  = 7'h5E;
  localparam logic [2:0] TOP_MULT_IMM  = 3'h6;
  localparam logic [4:0] LO_AUX_LONG   = 5'h01;
  localparam logic [4:0] LO_AUX_PTR    = 5'h11;
  localparam logic [3:0] NIB_OR_SHIFT  = 4'hC;
  localparam logic [7:0] LB_OR16       = 8'h82;
  localparam logic [7:0] LB_PAC        = 8'h03;
  localparam logic [7:0] CONST_ZERO    = 8'h00;
  localparam logic [4:0] SHIFT_OR16    = 5'h10;

  ////////////////////////////////////////////////////////////////////////
  // Word and cycle counts
  localparam logic [1:0] WORDS_ONE  = 2'h1;
  localparam logic [1:0] WORDS_TWO  = 2'h2;
  localparam logic [1:0] CYC_ONE    = 2'h1;
  localparam logic [1:0] CYC_TWO    = 2'h2;
  localparam logic [1:0] CYC_THREE  = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // Operations and states
  typedef enum logic [4:0] {
    none_op                   = 5'h00,
    acc_short_load_op         = 5'h01,
    acc_high_load_op          = 5'h02,
    acc_low_load_op           = 5'h03,
    acc_load_temp_multiplier_register_shift_op    = 5'h04,
    aux_reg_load_op           = 5'h05,
    aux_short_load_op         = 5'h06,
    aux_long_load_op          = 5'h07,
    page_pointer_load_op      = 5'h08,
    page_imm_load_op          = 5'h09,
    status_load_op            = 5'h0A,
    status_one_load_op        = 5'h0B,
    temp_reg_load_op          = 5'h0C,
    temp_load_accumulate_op   = 5'h0D,
    temp_load_product_move_op = 5'h0E,
    temp_load_subtract_op     = 5'h0F,
    temp_load_acc_move_op     = 5'h10,
    product_high_load_op      = 5'h11,
    multiply_accumulate_op    = 5'h12,
    multiply_accumulate_move_op = 5'h13,
    aux_reg_modify_op         = 5'h14,
    aux_ptr_load_op           = 5'h15,
    multiply_op               = 5'h16,
    multiply_imm_op           = 5'h17,
    multiply_add_prev_op      = 5'h18,
    multiply_sub_prev_op      = 5'h19,
    multiply_unsigned_op      = 5'h1A,
    normalize_op              = 5'h1B,
    or_mem_op                 = 5'h1C,
    or_imm_shift_op           = 5'h1D,
    or_imm_high_op            = 5'h1E,
    product_to_acc_op         = 5'h1F
  } dsplmd_op_t;

  typedef enum logic {
    st_opcode   = 1'b0,
    st_constant = 1'b1
  } dsplmd_state_t;

endpackage : dsplmd_pkg

//--- hdl/dsplmd_addr_field.sv
// Operand address field register of the opcode decoder.
// Assumes i_load pulses once per accepted opcode word.
`timescale 1ns/1ns
module dsplmd_addr_field (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Opcode word
  input  wire logic       i_load,
  input  wire logic       i_mem_ref,
  input  wire logic [7:0] i_field,
  // Decoded field
  output logic            o_mem_ref,
  output logic            o_indirect,
  output logic [6:0]      o_dir_offset,
  output logic [6:0]      o_ind_mode
);

  ////////////////////////////////////////////////////////////////////////
  // Top bit picks direct offset or indirect mode
  wire       ind_sel = i_field[7];
  wire [6:0] low7    = i_field[6:0];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_ref    <= 1'b0;
      o_indirect   <= 1'b0;
      o_dir_offset <= 7'h00;
      o_ind_mode   <= 7'h00;
    end else if (i_load) begin
      o_mem_ref    <= i_mem_ref;
      o_indirect   <= i_mem_ref & ind_sel;
      o_dir_offset <= (i_mem_ref & ~ind_sel) ? low7 : 7'h00;
      o_ind_mode   <= (i_mem_ref & ind_sel) ? low7 : 7'h00;
    end
  end

endmodule : dsplmd_addr_field

//--- dv/dsplmd_prog_mem.sv
// Program memory model that feeds instruction words to the decoder.
// Assumes the bench queues words in program order, constants after opcodes.
`timescale 1ns/1ns
module dsplmd_prog_mem (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Pacing
  input  wire logic        i_slow,
  // Instruction words
  output logic             o_instr_valid,
  output logic [15:0]      o_instr
);
  logic [15:0] words_q[$];
  integer      seed = 32'h29C9DDBC;

  task automatic push(input logic [15:0] w);
    words_q.push_back(w);
  endtask : push

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_instr_valid <= 1'b0;
      o_instr       <= 16'hA5A5;
    end else if (words_q.size() > 0 && (!i_slow || ($random(seed) & 1) == 0)) begin
      o_instr_valid <= 1'b1;
      o_instr       <= words_q.pop_front();
    end else begin
      // Idle bus inverts every bit each cycle, so every second idle cycle shows the stale word again
      o_instr_valid <= 1'b0;
      o_instr       <= ~o_instr;
    end
  end
endmodule : dsplmd_prog_mem

//--- dv/tb_top.sv
// Self-checking bench for the load/multiply opcode decoder.
// Assumes the program memory model in the same folder.
`timescale 1ns/1ns
module tb_top;
  logic                   i_clk, i_rst_n, i_instr_valid, slow, o_op_valid;
  logic                   o_acc_clear, o_unknown, o_mem_ref, o_indirect, o_await_const;
  logic [2:0]             o_aux_sel;
  logic [15:0]            i_instr, o_imm;
  logic [1:0]             o_words, o_cycles;
  logic [4:0]             o_shift;
  logic [6:0]             o_dir_offset, o_ind_mode;
  logic [51:0]            seen, exp_v, exp_m;
  logic [51:0]            exp_q[$], msk_q[$];
  dsplmd_pkg::dsplmd_op_t o_op;
  integer                 seed = 32'h29C9DDBC;
  int                     miscompares = 0;
  int                     samples_checked = 0;

  dsplmd_prog_mem u_dsplmd_prog_mem (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(slow),
    .o_instr_valid(i_instr_valid), .o_instr(i_instr));
  dsplmd_decoder u_dsplmd_decoder (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .o_op_valid(o_op_valid), .o_op(o_op), .o_words(o_words), .o_cycles(o_cycles),
    .o_aux_sel(o_aux_sel), .o_imm(o_imm), .o_shift(o_shift), .o_acc_clear(o_acc_clear), .o_unknown(o_unknown),
    .o_await_const(o_await_const), .o_mem_ref(o_mem_ref), .o_indirect(o_indirect), .o_dir_offset(o_dir_offset),
    .o_ind_mode(o_ind_mode));

  assign seen = {o_op, o_words, o_cycles, o_imm, o_acc_clear, o_shift, o_unknown,
                 o_mem_ref, o_indirect, o_dir_offset, o_ind_mode, o_aux_sel, o_await_const};

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [51:0] got, input logic [51:0] want);
    samples_checked++;
    if (got !== want) begin
      miscompares++;
      $display("mismatch at %0t: decoded %h, expected %h", $time, got, want);
    end
  endtask : check

  // Immediate and address fields are masked where the form carries none
  task automatic add(input logic [15:0] w1, input logic [15:0] w2, input dsplmd_pkg::dsplmd_op_t op,
                     input logic [1:0] wd, input logic [1:0] cy, input logic [15:0] im,
                     input logic ic, input logic mr, input logic [4:0] sh);
    logic       ac;
    logic       am;
    logic [6:0] f;
    logic [2:0] a;
    ac = (op == dsplmd_pkg::acc_short_load_op) && (w1[7:0] == 8'h00);
    f  = w1[6:0];
    am = op inside {dsplmd_pkg::aux_reg_load_op, dsplmd_pkg::aux_short_load_op,
                    dsplmd_pkg::aux_long_load_op, dsplmd_pkg::aux_ptr_load_op};
    a  = (op == dsplmd_pkg::aux_long_load_op || op == dsplmd_pkg::aux_ptr_load_op) ? w1[2:0] : w1[10:8];
    exp_q.push_back({op, wd, cy, im, ac, sh, op == dsplmd_pkg::none_op, mr, mr & w1[7],
                     (mr & !w1[7]) ? f : 7'h00, (mr & w1[7]) ? f : 7'h00, am ? a : 3'h0, 1'b0});
    msk_q.push_back({9'h1FF, {16{ic}}, 7'h7F, 1'b1, {15{mr}}, {3{am}}, 1'b1});
    u_dsplmd_prog_mem.push(w1);
    if (wd == 2'h2) u_dsplmd_prog_mem.push(w2);
  endtask : add

  task automatic mem(input logic [7:0] hb, input dsplmd_pkg::dsplmd_op_t op, input logic [1:0] cy);
    logic [7:0] lo;
    lo = 8'($random(seed));
    add({hb, lo}, 16'h0000, op, 2'h1, cy, 16'h0000, 1'b0, 1'b1, 5'h00);
  endtask : mem

  task automatic run_table;
    logic [15:0] r;
    logic [15:0] k;
    r = 16'($random(seed));
    k = 16'($random(seed));
    add({8'hB9, r[7:0]}, 16'h0000, dsplmd_pkg::acc_short_load_op, 2'h1, 2'h1, {8'h00, r[7:0]}, 1'b1, 1'b0, 5'h00);
    add(16'hB900, 16'h0000, dsplmd_pkg::acc_short_load_op, 2'h1, 2'h1, 16'h0000, 1'b1, 1'b0, 5'h00);
    mem(8'h6A, dsplmd_pkg::acc_high_load_op, 2'h1);
    mem(8'h69, dsplmd_pkg::acc_low_load_op, 2'h1);
    mem(8'h6B, dsplmd_pkg::acc_load_temp_multiplier_register_shift_op, 2'h1);
    mem({5'h00, r[10:8]}, dsplmd_pkg::aux_reg_load_op, 2'h2);
    add({5'h16, r[10:0]}, 16'h0000, dsplmd_pkg::aux_short_load_op, 2'h1, 2'h2, {8'h00, r[7:0]}, 1'b1, 1'b0, 5'h00);
    add({13'h17E1, r[2:0]}, k, dsplmd_pkg::aux_long_load_op, 2'h2, 2'h2, k, 1'b1, 1'b0, 5'h00);
    mem(8'h0D, dsplmd_pkg::page_pointer_load_op, 2'h2);
    add({7'h5E, r[8:0]}, 16'h0000, dsplmd_pkg::page_imm_load_op, 2'h1, 2'h2, {7'h00, r[8:0]}, 1'b1, 1'b0, 5'h00);
    mem(8'h0E, dsplmd_pkg::status_load_op, 2'h2);
    mem(8'h0F, dsplmd_pkg::status_one_load_op, 2'h2);
    mem(8'h73, dsplmd_pkg::temp_reg_load_op, 2'h1);
    mem(8'h70, dsplmd_pkg::temp_load_accumulate_op, 2'h1);
    mem(8'h71, dsplmd_pkg::temp_load_product_move_op, 2'h1);
    mem(8'h74, dsplmd_pkg::temp_load_subtract_op, 2'h1);
    mem(8'h72, dsplmd_pkg::temp_load_acc_move_op, 2'h1);
    mem(8'h75, dsplmd_pkg::product_high_load_op, 2'h1);
    add({8'hA2, r[7:0]}, k, dsplmd_pkg::multiply_accumulate_op, 2'h2, 2'h3, k, 1'b1, 1'b1, 5'h00);
    add({8'hA3, r[15:8]}, ~k, dsplmd_pkg::multiply_accumulate_move_op, 2'h2, 2'h3, ~k, 1'b1, 1'b1, 5'h00);
    add({8'h8B, r[7:0] & 8'hF7}, 16'h0000, dsplmd_pkg::aux_reg_modify_op, 2'h1, 2'h1, 16'h0000, 1'b0, 1'b1, 5'h00);
    add({13'h1171, r[2:0]}, 16'h0000, dsplmd_pkg::aux_ptr_load_op, 2'h1, 2'h1, 16'h0000, 1'b0, 1'b0, 5'h00);
    mem(8'h54, dsplmd_pkg::multiply_op, 2'h1);
    add({3'h6, r[12:0]}, 16'h0000, dsplmd_pkg::multiply_imm_op, 2'h1, 2'h1, {3'h0, r[12:0]}, 1'b1, 1'b0, 5'h00);
    mem(8'h50, dsplmd_pkg::multiply_add_prev_op, 2'h1);
    mem(8'h51, dsplmd_pkg::multiply_sub_prev_op, 2'h1);
    mem(8'h55, dsplmd_pkg::multiply_unsigned_op, 2'h1);
    mem(8'hA0, dsplmd_pkg::normalize_op, 2'h1);
    mem(8'h6D, dsplmd_pkg::or_mem_op, 2'h1);
    add({12'hBFC, r[3:0]}, k, dsplmd_pkg::or_imm_shift_op, 2'h2, 2'h2, k, 1'b1, 1'b0, {1'b0, r[3:0]});
    add(16'hBE82, k, dsplmd_pkg::or_imm_high_op, 2'h2, 2'h2, k, 1'b1, 1'b0, 5'h10);
    add(16'hBE03, 16'h0000, dsplmd_pkg::product_to_acc_op, 2'h1, 2'h1, 16'h0000, 1'b0, 1'b0, 5'h00);
    add(16'hBE02, 16'h0000, dsplmd_pkg::none_op, 2'h1, 2'h1, 16'h0000, 1'b0, 1'b0, 5'h00);
  endtask : run_table

  task automatic complete_run;
    $display("Compared %0d results, %0d mismatches", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Bounded wait for every queued result to come back
  task automatic drain;
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge i_clk);
    if (exp_q.size() > 0) begin
      miscompares++;
      $display("mismatch at %0t: %0d results never appeared", $time, exp_q.size());
      complete_run();
    end
    repeat (3) @(posedge i_clk);
  endtask : drain

  ////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    if (o_op_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("mismatch at %0t: unexpected decode pulse", $time);
      end else begin
        exp_v = exp_q.pop_front();
        exp_m = msk_q.pop_front();
        check(seen & exp_m, exp_v);
      end
    end
  end

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial begin
    i_rst_n = 1'b0;
    slow    = 1'b0;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    run_table();
    drain();
    $display("Test back-to-back words done");
    slow <= 1'b1;
    repeat (3) run_table();
    drain();
    $display("Test stalled words done");
    complete_run();
  end
endmodule : tb_top
